// [line_regs_pkg.sv]
// Package for the line interface control register bank.
// Assumes an AXI4-Lite master with 32-bit data and 10 MHz aclk.
package line_regs_pkg;

  localparam int          AXI_ADDR_W = 8;
  localparam logic [7:0]  OFFS_LINE_HOOK   = 8'h00;
  localparam logic [7:0]  OFFS_POWER_PATH  = 8'h04;
  localparam logic [7:0]  OFFS_LINK_LOCK   = 8'h08;
  localparam logic [7:0]  OFFS_MON_GAIN    = 8'h10;
  localparam logic [7:0]  OFFS_RING_SEL    = 8'h14;
  localparam logic [7:0]  OFFS_LINE_INPUT  = 8'h18;

  localparam logic [7:0]  RST_LINE_HOOK    = 8'h40;
  localparam logic [7:0]  RST_POWER_PATH   = 8'h0C;
  localparam logic [7:0]  RST_MON_GAIN     = 8'h0F;
  localparam logic [7:0]  RST_RING_SEL     = 8'h00;

  // Writable bit masks and the power path keep mask; reserved bits that read zero are masked out
  localparam logic [7:0]  MASK_LINE_HOOK   = 8'hC3;
  localparam logic [7:0]  MASK_POWER_PATH  = 8'h74;
  localparam logic [7:0]  KEEP_POWER_PATH  = 8'h0B;
  localparam logic [7:0]  MASK_MON_GAIN    = 8'h0F;
  localparam logic [7:0]  MASK_RING_SEL    = 8'h01;

  localparam int          SPEED_LSB      = 6;
  localparam int          DEV_PDOWN_BIT  = 6;
  localparam int          LINE_PDOWN_BIT = 5;
  localparam int          FORCE_DIS_BIT  = 4;
  localparam int          HYB_BIT = 2;
  localparam int          LOCK_BIT = 3;
  localparam int          RXG_LSB = 2;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Off-hook counter lengths in ms
  localparam int          OFFHOOK_MS_00 = 512;
  localparam int          OFFHOOK_MS_01 = 128;
  localparam int          OFFHOOK_MS_10 = 64;
  localparam int          OFFHOOK_MS_11 = 8;
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          CYC_PER_MS    = CLK_HZ / 1000;

  typedef enum logic [1:0] {
    LINE_ONHOOK,
    LINE_OFFHOOK,
    LINE_MONITOR,
    LINE_RESERVED
  } line_state_t;

  typedef struct packed {
    logic [1:0]  offhook_speed_sel;
    line_state_t line_state_sel;
    logic        device_powerdown;
    logic        lineside_powerdown;
    logic        line_volt_force_disable;
    logic        hybrid_tx_connect;
    logic [1:0]  monitor_rx_gain;
    logic [1:0]  monitor_tx_gain;
    logic        ring_level_sel;
  } line_ctrl_t;

  typedef struct packed {
    logic [AXI_ADDR_W-1:0] awaddr;
    logic                  awvalid;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  wvalid;
    logic                  bready;
    logic [AXI_ADDR_W-1:0] araddr;
    logic                  arvalid;
    logic                  rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_rsp_t;

endpackage

// [line_ctrl_regs.sv]
// Line interface control registers behind an AXI4-Lite slave.
// Assumes synchronous inputs on aclk and a synchronous active-low reset.
`timescale 1ns/1ps

module line_ctrl_regs #(
  parameter int VOLT_W = 8
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire line_regs_pkg::axil_req_t  axi_req,
  output line_regs_pkg::axil_rsp_t       axi_rsp,
  input  wire logic                      ctrl_line_we,
  input  wire line_regs_pkg::line_state_t ctrl_line_state,
  input  wire logic                      frame_locked,
  input  wire logic [VOLT_W-1:0]         line_voltage_raw,
  input  wire logic                      line_at_or_below_3v,
  input  wire logic                      offhook_start,
  output line_regs_pkg::line_ctrl_t      line_ctrl,
  output logic [VOLT_W-1:0]              line_voltage_status,
  output logic                           offhook_done
);
  import line_regs_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0]  line_hook;
  logic [7:0]  power_path;
  logic [7:0]  mon_gain;
  logic [7:0]  ring_sel;
  logic        frame_lock_flag;

  //////////////////////////////////////////////////////////////////////////////
  // AXI write path: address and data taken in either order

  logic                  aw_held;
  logic                  w_held;
  logic [AXI_ADDR_W-1:0] aw_addr;
  logic [31:0]           w_data;
  logic                  w_lane0;
  logic                  aw_ready;
  logic                  w_ready;
  logic                  b_valid;
  logic [1:0]            b_resp;

  // A channel is taken only while its ready is shown
  wire aw_take  = axi_req.awvalid && aw_ready;
  wire w_take   = axi_req.wvalid && w_ready;
  wire aw_have  = aw_held || aw_take;
  wire w_have   = w_held || w_take;
  wire do_write = aw_have && w_have && !b_valid;

  wire [AXI_ADDR_W-1:0] wr_addr = aw_held ? aw_addr : axi_req.awaddr;
  wire [31:0]           wr_word = w_held ? w_data : axi_req.wdata;
  wire                  wr_lane = w_held ? w_lane0 : axi_req.wstrb[0];
  wire [7:0]            wr_byte = wr_word[7:0];

  wire wr_hook  = do_write && wr_lane && (wr_addr == OFFS_LINE_HOOK);
  wire wr_power = do_write && wr_lane && (wr_addr == OFFS_POWER_PATH);
  wire wr_gain  = do_write && wr_lane && (wr_addr == OFFS_MON_GAIN);
  wire wr_ring  = do_write && wr_lane && (wr_addr == OFFS_RING_SEL);
  wire wr_known = (wr_addr == OFFS_LINE_HOOK) || (wr_addr == OFFS_POWER_PATH) ||
                  (wr_addr == OFFS_MON_GAIN) || (wr_addr == OFFS_RING_SEL) ||
                  (wr_addr == OFFS_LINK_LOCK) || (wr_addr == OFFS_LINE_INPUT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_lane0 <= 1'b0;
    end else begin
      aw_held <= do_write ? 1'b0 : aw_have;
      w_held  <= do_write ? 1'b0 : w_have;
      if (aw_take) begin
        aw_addr <= axi_req.awaddr;
      end
      if (w_take) begin
        w_data  <= axi_req.wdata;
        w_lane0 <= axi_req.wstrb[0];
      end
    end
  end

  // Each ready is offered only while its own channel holds nothing and no write or response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ready <= 1'b0;
    end else begin
      aw_ready <= !aw_have && !do_write && !b_valid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_ready <= 1'b0;
    end else begin
      w_ready <= !w_have && !do_write && !b_valid;
    end
  end

  // Response stands until bready is seen high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      b_valid <= 1'b0;
      b_resp  <= RESP_OKAY;
    end else if (do_write) begin
      b_valid <= 1'b1;
      b_resp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (axi_req.bready) begin
      b_valid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Line mode code 11 is reserved; a write of it leaves the mode unchanged
  wire [1:0] next_line_mode = (wr_byte[1:0] == LINE_RESERVED) ? line_hook[1:0] :
                              wr_byte[1:0];

  // Controller update of the mode bits beats a bus write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_hook <= RST_LINE_HOOK;
    end else begin
      if (wr_hook) begin
        line_hook <= {wr_byte[7:6], 4'h0, next_line_mode} & MASK_LINE_HOOK;
      end
      if (ctrl_line_we && ctrl_line_state != LINE_RESERVED) begin
        line_hook[1:0] <= ctrl_line_state;
      end
    end
  end

  // Do-not-modify bits keep their value whatever is written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_path <= RST_POWER_PATH;
    end else if (wr_power) begin
      power_path <= (wr_byte & MASK_POWER_PATH) |
                    (power_path & KEEP_POWER_PATH);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon_gain <= RST_MON_GAIN;
    end else if (wr_gain) begin
      mon_gain <= wr_byte & MASK_MON_GAIN;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ring_sel <= RST_RING_SEL;
    end else if (wr_ring) begin
      ring_sel <= wr_byte & MASK_RING_SEL;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status and line-side outputs

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_lock_flag     <= 1'b0;
      line_voltage_status <= '0;
      line_ctrl           <= '0;
    end else begin
      frame_lock_flag <= frame_locked;
      if (line_at_or_below_3v && !power_path[FORCE_DIS_BIT]) begin
        line_voltage_status <= '0;
      end else begin
        line_voltage_status <= line_voltage_raw;
      end
      line_ctrl.offhook_speed_sel       <= line_hook[SPEED_LSB +: 2];
      line_ctrl.line_state_sel          <= line_state_t'(line_hook[1:0]);
      line_ctrl.device_powerdown        <= power_path[DEV_PDOWN_BIT];
      line_ctrl.lineside_powerdown      <= power_path[LINE_PDOWN_BIT];
      line_ctrl.line_volt_force_disable <= power_path[FORCE_DIS_BIT];
      line_ctrl.hybrid_tx_connect       <= power_path[HYB_BIT];
      line_ctrl.monitor_rx_gain         <= mon_gain[RXG_LSB +: 2];
      line_ctrl.monitor_tx_gain         <= mon_gain[1:0];
      line_ctrl.ring_level_sel          <= ring_sel[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Off-hook counter

  localparam int OH_W = $clog2(OFFHOOK_MS_00 * CYC_PER_MS + 1);
  localparam logic [OH_W-1:0] OH_CYC_00 = OH_W'(OFFHOOK_MS_00 * CYC_PER_MS);
  localparam logic [OH_W-1:0] OH_CYC_01 = OH_W'(OFFHOOK_MS_01 * CYC_PER_MS);
  localparam logic [OH_W-1:0] OH_CYC_10 = OH_W'(OFFHOOK_MS_10 * CYC_PER_MS);
  localparam logic [OH_W-1:0] OH_CYC_11 = OH_W'(OFFHOOK_MS_11 * CYC_PER_MS);

  logic [OH_W-1:0] oh_count;
  logic            oh_run;

  wire [1:0] speed_code = line_hook[SPEED_LSB +: 2];
  wire [OH_W-1:0] oh_len = (speed_code == 2'h0) ? OH_CYC_00 :
                           (speed_code == 2'h1) ? OH_CYC_01 :
                           (speed_code == 2'h2) ? OH_CYC_10 : OH_CYC_11;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oh_count     <= '0;
      oh_run       <= 1'b0;
      offhook_done <= 1'b0;
    end else begin
      offhook_done <= 1'b0;
      if (offhook_start) begin
        oh_count <= oh_len - OH_W'(1);
        oh_run   <= 1'b1;
      end else if (oh_run) begin
        if (oh_count == '0) begin
          oh_run       <= 1'b0;
          offhook_done <= 1'b1;
        end else begin
          oh_count <= oh_count - OH_W'(1);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI read path

  logic        ar_ready;
  logic        r_valid;
  logic [31:0] r_data;
  logic [1:0]  r_resp;

  wire ar_take = axi_req.arvalid && ar_ready;
  wire [7:0] lock_byte = 8'(frame_lock_flag) << LOCK_BIT;
  wire [7:0] rd_byte =
    (axi_req.araddr == OFFS_LINE_HOOK)  ? line_hook :
    (axi_req.araddr == OFFS_POWER_PATH) ? power_path :
    (axi_req.araddr == OFFS_LINK_LOCK)  ? lock_byte :
    (axi_req.araddr == OFFS_MON_GAIN)   ? mon_gain :
    (axi_req.araddr == OFFS_RING_SEL)   ? ring_sel :
    (axi_req.araddr == OFFS_LINE_INPUT) ? line_voltage_status[7:0] : 8'h00;
  wire rd_known = (axi_req.araddr == OFFS_LINE_HOOK) ||
                  (axi_req.araddr == OFFS_POWER_PATH) ||
                  (axi_req.araddr == OFFS_LINK_LOCK) ||
                  (axi_req.araddr == OFFS_MON_GAIN) ||
                  (axi_req.araddr == OFFS_RING_SEL) ||
                  (axi_req.araddr == OFFS_LINE_INPUT);

  // Address is refused again until the data has been taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_ready <= 1'b0;
    end else begin
      ar_ready <= !r_valid && !ar_take;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_valid <= 1'b0;
    end else if (ar_take) begin
      r_valid <= 1'b1;
    end else if (axi_req.rready) begin
      r_valid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_data <= '0;
      r_resp <= RESP_OKAY;
    end else if (ar_take) begin
      r_data <= {24'h000000, rd_byte};
      r_resp <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus outputs, each straight from its flip-flop

  assign axi_rsp = '{
    awready: aw_ready,
    wready:  w_ready,
    bresp:   b_resp,
    bvalid:  b_valid,
    arready: ar_ready,
    rdata:   r_data,
    rresp:   r_resp,
    rvalid:  r_valid
  };

endmodule

// [line_ctrl_regs_chk.sv]
// Checker for the line interface control register bank.
// Assumes it is bound to line_ctrl_regs and sees only that module's ports.
`timescale 1ns/1ps
module line_ctrl_regs_chk #(
  parameter int VOLT_W = 8
) (
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire line_regs_pkg::axil_req_t    axi_req,
  input wire line_regs_pkg::axil_rsp_t    axi_rsp,
  input wire logic                        ctrl_line_we,
  input wire line_regs_pkg::line_state_t  ctrl_line_state,
  input wire logic                        frame_locked,
  input wire logic [VOLT_W-1:0]           line_voltage_raw,
  input wire logic                        line_at_or_below_3v,
  input wire logic                        offhook_start,
  input wire line_regs_pkg::line_ctrl_t   line_ctrl,
  input wire logic [VOLT_W-1:0]           line_voltage_status,
  input wire logic                        offhook_done
);
  import line_regs_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire aw_take = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  wire ar_take = axi_req.arvalid && axi_rsp.arready;
  ////////////////////////////////////////////////////////////////////////////////
  sequence forced_low;
    line_at_or_below_3v && !line_ctrl.line_volt_force_disable
      ##1 !line_ctrl.line_volt_force_disable;
  endsequence
  sequence lock_steady;
    $stable(frame_locked) [*3];
  endsequence
  a_volt_forced: assert property (forced_low |-> line_voltage_status == '0)
    else $error("line voltage status not forced to zero");
  a_volt_pass: assert property (!line_at_or_below_3v
    |=> line_voltage_status == $past(line_voltage_raw))
    else $error("line voltage status not passed through");
  a_lock_read: assert property (lock_steady ##0 (ar_take && axi_req.araddr == 8'h08)
    |=> axi_rsp.rdata == {28'h0, $past(frame_locked), 3'h0})
    else $error("frame lock flag read wrong");
  a_line_port: assert property (ctrl_line_we && ctrl_line_state != LINE_RESERVED
    |-> ##2 line_ctrl.line_state_sel == $past(ctrl_line_state, 2))
    else $error("controller line mode not applied");
  a_write_answer: assert property (aw_take |=> axi_rsp.bvalid)
    else $error("write response missing");
  a_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready
    |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped early");
  a_read_answer: assert property (ar_take |=> axi_rsp.rvalid)
    else $error("read response missing");
  a_bad_addr: assert property (aw_take && axi_req.awaddr == 8'h0C |=> axi_rsp.bresp == 2'h2)
    else $error("unmapped write not refused");
endmodule

// [daa_line_control_regs_test.sv]
// Self-checking bench for the line interface control register bank.
// Assumes the design package and line_ctrl_regs_chk are compiled first.
`timescale 1ns/1ps
module daa_line_control_regs_test;
  import line_regs_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, ctrl_line_we = 1'b0, frame_locked = 1'b0;
  logic        line_at_or_below_3v = 1'b0, offhook_start = 1'b0, offhook_done;
  logic [7:0]  line_voltage_raw = 8'h00, line_voltage_status;
  line_state_t ctrl_line_state = LINE_ONHOOK;
  axil_req_t   axi_req = '0;
  axil_rsp_t   axi_rsp;
  line_ctrl_t  line_ctrl;
  int          n_fail = 0, checks = 0, cyc = 0;
  logic [1:0]  r;
  always #50 aclk = ~aclk;
  line_ctrl_regs #(.VOLT_W(8)) DUT (
    .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .ctrl_line_we(ctrl_line_we), .ctrl_line_state(ctrl_line_state),
    .frame_locked(frame_locked), .line_voltage_raw(line_voltage_raw),
    .line_at_or_below_3v(line_at_or_below_3v), .offhook_start(offhook_start),
    .line_ctrl(line_ctrl), .line_voltage_status(line_voltage_status),
    .offhook_done(offhook_done));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (axi_rsp.awready === 1'b1) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready === 1'b1) axi_req.wvalid <= 1'b0;
    end while (axi_rsp.bvalid !== 1'b1);
    resp = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (axi_rsp.arready === 1'b1) axi_req.arvalid <= 1'b0;
    end while (axi_rsp.rvalid !== 1'b1);
    d = axi_rsp.rdata;
    resp = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d, r);
    chk("rresp", r, 32'h0);
    chk("rdata", d, exp);
  endtask
  task automatic wrs(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, r);
    repeat (3) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk(8'h00, 32'h40);
    rdchk(8'h04, 32'h0C);
    rdchk(8'h08, 32'h00);
    rdchk(8'h10, 32'h0F);
    rdchk(8'h14, 32'h00);
    chk("speed", line_ctrl.offhook_speed_sel, 32'h1);
  endtask
  task automatic t_line;
    for (int i = 0; i < 3; i++) begin
      wrs(8'h00, (i << 6) | i);
      chk("speed", line_ctrl.offhook_speed_sel, i);
      chk("mode", line_ctrl.line_state_sel, i);
    end
    wrs(8'h00, 32'hFF);
    rdchk(8'h00, 32'hC2);
  endtask
  task automatic t_power;
    logic [31:0] d;
    wrs(8'h04, 32'hFF);
    rdchk(8'h04, 32'h7C);
    chk("pwr", {line_ctrl.device_powerdown, line_ctrl.lineside_powerdown,
                line_ctrl.line_volt_force_disable,
                line_ctrl.hybrid_tx_connect}, 32'hF);
    wrs(8'h04, 32'h00);
    rdchk(8'h04, 32'h08);
    line_voltage_raw <= 8'h5A;
    line_at_or_below_3v <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("lvs", line_voltage_status, 32'h0);
    wrs(8'h04, 32'h10);
    chk("lvs", line_voltage_status, 32'h5A);
    line_at_or_below_3v <= 1'b0;
    rd(8'h04, d, r);
    wrs(8'h04, d | 32'h04);
    rdchk(8'h04, 32'h1C);
    chk("hyb", line_ctrl.hybrid_tx_connect, 32'h1);
  endtask
  task automatic t_gain;
    for (int i = 0; i < 16; i++) begin
      wrs(8'h10, 32'hF0 | i);
      rdchk(8'h10, i);
      chk("gain", {line_ctrl.monitor_rx_gain, line_ctrl.monitor_tx_gain}, i);
    end
    wrs(8'h14, 32'hFF);
    rdchk(8'h14, 32'h1);
    chk("ring", line_ctrl.ring_level_sel, 32'h1);
  endtask
  task automatic t_port;
    logic [1:0] s[4] = '{2'h1, 2'h0, 2'h2, 2'h3};
    for (int i = 0; i < 4; i++) begin
      ctrl_line_state <= line_state_t'(s[i]);
      ctrl_line_we <= 1'b1;
      @(posedge aclk);
      ctrl_line_we <= 1'b0;
      repeat (3) @(posedge aclk);
      chk("port", line_ctrl.line_state_sel, (i == 3) ? 32'h2 : s[i]);
    end
  endtask
  task automatic t_misc;
    logic [31:0] d;
    frame_locked <= 1'b1;
    repeat (4) @(posedge aclk);
    rdchk(8'h08, 32'h08);
    wr(8'h0C, 32'hFF, r);
    chk("bresp", r, 32'h2);
    rd(8'h0C, d, r);
    chk("rresp", r, 32'h2);
    chk("rdata", d, 32'h0);
  endtask
  task automatic t_offhook;
    int n;
    wrs(8'h00, 32'hC0);
    offhook_start <= 1'b1;
    @(posedge aclk);
    offhook_start <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (offhook_done !== 1'b1);
    chk("offhook", n, 32'd80001);
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_line();
    t_power();
    t_gain();
    t_port();
    t_misc();
    t_offhook();
    give_verdict();
  end
endmodule
bind line_ctrl_regs line_ctrl_regs_chk #(.VOLT_W(VOLT_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .ctrl_line_we(ctrl_line_we), .ctrl_line_state(ctrl_line_state),
  .frame_locked(frame_locked), .line_voltage_raw(line_voltage_raw),
  .line_at_or_below_3v(line_at_or_below_3v), .offhook_start(offhook_start),
  .line_ctrl(line_ctrl), .line_voltage_status(line_voltage_status),
  .offhook_done(offhook_done));
